// ### verif/dea_ctrl_checker.sv
// Port assertions for the data EEPROM access controller.
// Bound to dea_ctrl; one clock, power-on reset asynchronous and high.
`timescale 1ns/10ps
`include "dea_regs.svh"

module dea_ctrl_checker
#(
    parameter int PROG_CYCLES = `DEA_PROG_CYCLES,
    parameter int PWRT_CYCLES = `DEA_PWRT_CYCLES
)
(
    // Clock, resets, register port
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ext_rst,
    input wire logic i_wdt_rst,
    input wire logic [`DEA_ADDR_W-1:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    // Outputs watched
    input wire logic [7:0] o_rdata,
    input wire logic o_busy,
    input wire logic o_done_flag,
    input wire logic o_aborted,
    input wire logic o_flash_start,
    input wire logic o_flash_row_erase
);
    // ------------------------------------------------------------
    // Helper counters
    // ------------------------------------------------------------
    logic [`DEA_CNT_W-1:0] run_reg;
    logic [`DEA_CNT_W-1:0] up_reg;

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            run_reg <= '0;
            up_reg <= '0;
        end
        else
        begin
            run_reg <= o_busy ? run_reg + 1'b1 : '0;
            if (up_reg < PWRT_CYCLES)
                up_reg <= up_reg + 1'b1;
        end
    end

    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);

    // Aborted runs end early, so only clean ends are timed
    sequence run_end;
        $fell(o_busy) && !$rose(o_aborted);
    endsequence
    sequence wd_hit;
        o_busy && i_wdt_rst;
    endsequence

    chk_run_length: assert property (run_end |-> run_reg == PROG_CYCLES)
        else $error("programming cycle length wrong");
    chk_done_set: assert property (run_end |-> o_done_flag)
        else $error("done flag not set at cycle end");
    chk_done_held: assert property (o_done_flag && !(i_wr && i_addr == `DEA_OFS_FLAG2)
        |=> o_done_flag)
        else $error("done flag dropped without software");
    chk_key_zero: assert property (i_rd && i_addr == `DEA_OFS_KEY |=> o_rdata == 8'h00)
        else $error("key port read not zero");
    chk_ctl_spare: assert property (i_rd && i_addr == `DEA_OFS_CTL
        |=> o_rdata[5] == 1'b0 && o_rdata[0] == 1'b0)
        else $error("control spare or fetch bit reads one");
    chk_launch_cause: assert property ($rose(o_busy) |-> $past(i_wr)
        && $past(i_addr) == `DEA_OFS_CTL && $past(i_wdata[1]))
        else $error("cycle started without launch write");
    chk_wd_abort: assert property (wd_hit |=> o_aborted && !o_busy)
        else $error("watchdog abort not flagged");
    chk_pwrt_block: assert property (up_reg < PWRT_CYCLES |-> !o_busy)
        else $error("cycle ran during power-up timer");
    chk_row_kept: assert property (i_wdt_rst && !i_wr |=> $stable(o_flash_row_erase))
        else $error("row wipe changed by warm reset");
    chk_flash_pulse: assert property (o_flash_start |-> $rose(o_busy) ##1 !o_flash_start)
        else $error("flash start pulse wrong");
endmodule

bind dea_ctrl dea_ctrl_checker #(.PROG_CYCLES(PROG_CYCLES), .PWRT_CYCLES(PWRT_CYCLES)) u_chk
(
    .i_clk, .i_rst, .i_ext_rst, .i_wdt_rst, .i_addr, .i_wdata, .i_wr, .i_rd,
    .o_rdata, .o_busy, .o_done_flag, .o_aborted, .o_flash_start, .o_flash_row_erase
);

// ### verif/test_dea_ctrl.sv
// Self-checking testbench for the data EEPROM access controller.
// Drives the register port directly; timing parameters shortened.
`timescale 1ns/10ps
`include "dea_regs.svh"

module test_dea_ctrl;
    localparam logic [11:0] CTL = `DEA_OFS_CTL;
    localparam logic [11:0] KEY = `DEA_OFS_KEY;
    localparam logic [11:0] BUF = `DEA_OFS_BUF;
    localparam logic [11:0] IDX = `DEA_OFS_IDX;
    localparam logic [11:0] FL2 = `DEA_OFS_FLAG2;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_ext_rst = 1'b0;
    logic i_wdt_rst = 1'b0;
    logic [11:0] i_addr = '0;
    logic [7:0] i_wdata = '0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [7:0] o_rdata;
    logic o_busy, o_done_flag, o_aborted, o_flash_start, o_flash_row_erase;
    int n_fail = 0;
    int total_checks = 0;

    dea_ctrl #(.PROG_CYCLES(8), .PWRT_CYCLES(12)) dut
    (
        .i_clk, .i_rst, .i_ext_rst, .i_wdt_rst, .i_addr, .i_wdata, .i_wr, .i_rd,
        .o_rdata, .o_busy, .o_done_flag, .o_aborted, .o_flash_start, .o_flash_row_erase
    );

    initial
        forever #50 i_clk = ~i_clk;

    // ------------------------------------------------------------
    // Bus and check tasks
    // ------------------------------------------------------------
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        total_checks++;
        if (s !== e)
        begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        chk(o_rdata & m, e);
    endtask

    // Bounded wait for the end of a programming cycle
    task automatic wt();
        for (int i = 0; i < 40 && o_busy === 1'b1; i++)
        begin
            @(posedge i_clk);
            #1;
        end
        if (o_busy !== 1'b0)
        begin
            n_fail++;
            results();
        end
    endtask

    // Unlock and launch run back to back, as with interrupts masked, unless brk puts a key port read between the key writes
    task automatic arm(input logic [7:0] k1, input logic [7:0] k2, input logic brk,
                       input logic [7:0] c = 8'h06);
        wr(KEY, k1);
        if (brk)
            rd(KEY, 8'h00);
        wr(KEY, k2);
        wr(CTL, c);
    endtask

    task automatic prog(input logic [7:0] a, input logic [7:0] d);
        wr(IDX, a);
        wr(BUF, d);
        wr(CTL, 8'h04);
        arm(8'h55, 8'haa, 1'b0);
        chk(o_busy, 1'b1);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_pwrt();
        wr(CTL, 8'h04);
        arm(8'h55, 8'haa, 1'b0);
        chk(o_busy, 1'b0);
        rd(CTL, 8'h04);
    endtask

    task automatic t_bad();
        logic [7:0] ka [4] = '{8'h55, 8'haa, 8'h55, 8'h55};
        logic [7:0] kb [4] = '{8'haa, 8'h55, 8'h55, 8'haa};
        logic [3:0] brk = 4'b0001;
        logic [3:0] pre = 4'b0111;
        for (int i = 0; i < 4; i++)
        begin
            wr(CTL, {5'h00, pre[i], 2'b00});
            arm(ka[i], kb[i], brk[i]);
            chk(o_busy, 1'b0);
        end
    endtask

    task automatic t_wr();
        prog(8'h00, 8'ha5);
        wr(IDX, 8'h77);
        wr(BUF, 8'h11);
        wr(CTL, 8'h00);
        wt();
        rd(FL2, 8'h10, 8'h10);
        rd(CTL, 8'h04);
        rd(IDX, 8'h00);
        rd(BUF, 8'ha5);
        wr(FL2, 8'h00);
        rd(FL2, 8'h00, 8'h10);
        prog(8'hff, 8'h3c);
        wt();
        for (int i = 0; i < 2; i++)
        begin
            wr(IDX, i ? 8'hff : 8'h00);
            wr(CTL, 8'h01);
            rd(BUF, i ? 8'h3c : 8'ha5);
        end
    endtask

    task automatic t_fetch();
        wr(IDX, 8'h00);
        wr(CTL, 8'h81);
        rd(BUF, 8'h3c);
        rd(12'h123, 8'h00);
        rd(BUF, 8'h3c);
    endtask

    task automatic t_row();
        wr(CTL, 8'h94);
        arm(8'h55, 8'haa, 1'b0, 8'h96);
        chk(o_flash_row_erase, 1'b1);
        chk(o_flash_start, 1'b1);
        wt();
        rd(CTL, 8'h84);
        wr(CTL, 8'hc4);
        rd(CTL, 8'hc4);
        wr(CTL, 8'h04);
    endtask

    // Warm reset in mid-cycle: watchdog when k is 0, reset pin otherwise
    task automatic t_abort(input logic k);
        prog(8'h10, 8'h5a);
        repeat (3) @(posedge i_clk);
        i_ext_rst <= k;
        i_wdt_rst <= !k;
        repeat (3) @(posedge i_clk);
        i_ext_rst <= 1'b0;
        i_wdt_rst <= 1'b0;
        repeat (3) @(posedge i_clk);
        #1;
        chk(o_aborted, 1'b1);
        rd(CTL, 8'h0c);
        rd(BUF, 8'h00);
        rd(IDX, 8'h00);
        prog(8'h10, 8'h5a);
        wt();
        wr(CTL, 8'h01);
        rd(BUF, 8'h5a);
        wr(CTL, 8'h00);
    endtask

    task automatic t_por();
        @(posedge i_clk);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
        rd(CTL, 8'h00, 8'h04);
    endtask

    initial
    begin
        repeat (20) @(posedge i_clk);
        i_rst <= 1'b0;
        t_pwrt();
        t_bad();
        t_wr();
        t_fetch();
        t_row();
        t_abort(1'b0);
        t_abort(1'b1);
        t_por();
        results();
    end
endmodule

// ### verilog/dea_ctrl.sv
// Indirect access controller for the on-chip data EEPROM: control,
// unlock key, byte buffer and byte index registers, plus the done flag.
// Assumes a same-clock register port, a watchdog reset pulse on this
// clock and an external reset pin that arrives asynchronously.
// PROG_CYCLES must be at least 2; PWRT_CYCLES is counted from the
// release of i_rst, and warm resets do not restart it.
//
// Strobed register access was left to the implementer.
`timescale 1ns/10ps
`include "dea_regs.svh"

module dea_ctrl
#(
    parameter int PROG_CYCLES = `DEA_PROG_CYCLES,
    parameter int PWRT_CYCLES = `DEA_PWRT_CYCLES
)
(
    // Clock and resets
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ext_rst,
    input wire logic i_wdt_rst,
    // Register port
    input wire logic [`DEA_ADDR_W-1:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // Status and program flash hooks
    output logic o_busy,
    output logic o_done_flag,
    output logic o_aborted,
    output logic o_flash_start,
    output logic o_flash_row_erase
);

    // ------------------------------------------------------------------
    // Derived counts
    // ------------------------------------------------------------------
    // Half the cycle erases, the rest stores; needs PROG_CYCLES >= 2
    localparam logic [`DEA_CNT_W-1:0] ERASE_LAST =
        `DEA_CNT_W'(PROG_CYCLES / 2 - 1);
    localparam logic [`DEA_CNT_W-1:0] STORE_LAST =
        `DEA_CNT_W'(PROG_CYCLES - PROG_CYCLES / 2 - 1);
    localparam logic [`DEA_CNT_W-1:0] PWRT_LOAD =
        `DEA_CNT_W'(PWRT_CYCLES);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    dea_pkg::dea_state_t st_reg;
    dea_pkg::dea_state_t st_next;

    // Non-volatile array: no reset, contents survive every reset
    logic [7:0] mem_reg [0:`DEA_DEPTH-1];

    logic warm;
    logic busy;
    logic erase_do;
    logic store_do;
    logic launch_ok;
    logic pwrt_done;
    logic permit_before;
    logic key_armed;
    logic any_access;
    logic key_wr;
    logic flag2_wr;
    logic [7:0] fetched;

    // ------------------------------------------------------------------
    // Decode and qualifiers
    // ------------------------------------------------------------------
    // Reads of the array are combinational; the buffer samples them
    assign fetched = mem_reg[st_reg.index];
    assign any_access = i_wr | i_rd;
    assign key_wr = i_wr && (i_addr == `DEA_OFS_KEY);
    assign flag2_wr = i_wr && (i_addr == `DEA_OFS_FLAG2);
    // Launches stay refused until the power-up timer has run out
    assign pwrt_done = (st_reg.pwrt_cnt == '0);
    // The permit bit is taken from before the write, so a write that
    // sets permit and launch while permit is still low never starts a cycle
    assign permit_before = st_reg.ctl.permit;
    assign key_armed = (st_reg.key == dea_pkg::DEA_KEY_ARMED);

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        st_next = st_reg;
        warm = 1'b0;
        busy = 1'b0;
        erase_do = 1'b0;
        store_do = 1'b0;
        launch_ok = 1'b0;
        // Read data is zero outside the cycle after a read
        st_next.rdata = 8'h00;
        st_next.flash_start = 1'b0;

        // Pin reset passes two flops; only the second is looked at
        st_next.ext_sync = {st_reg.ext_sync[0], i_ext_rst};
        warm = st_reg.ext_sync[1] | i_wdt_rst;
        busy = st_reg.ctl.launch;

        if (st_reg.pwrt_cnt != '0)
        begin
            st_next.pwrt_cnt = st_reg.pwrt_cnt - 1'b1;
        end

        // Register reads, data presented in the following cycle
        if (i_rd)
        begin
            unique case (i_addr)
                `DEA_OFS_CTL:
                begin
                    st_next.rdata = {st_reg.ctl.flash_sel,
                                     st_reg.ctl.cfg_sel,
                                     1'b0,
                                     st_reg.ctl.row_wipe,
                                     st_reg.ctl.aborted,
                                     st_reg.ctl.permit,
                                     st_reg.ctl.launch,
                                     1'b0};
                end
                `DEA_OFS_KEY:
                begin
                    st_next.rdata = 8'h00;
                end
                `DEA_OFS_BUF:
                begin
                    st_next.rdata = st_reg.buffer;
                end
                `DEA_OFS_IDX:
                begin
                    st_next.rdata = st_reg.index;
                end
                `DEA_OFS_FLAG2:
                begin
                    st_next.rdata = 8'h00;
                    st_next.rdata[`DEA_FLAG2_DONE] = st_reg.done_flag;
                end
                // Unmapped addresses read as zero
                default:
                begin
                    st_next.rdata = 8'h00;
                end
            endcase
        end

        // Unlock tracking: any access that is not the next step
        // drops back to the start
        if (any_access)
        begin
            st_next.key = dea_pkg::DEA_KEY_NONE;
        end
        // A 55h write always restarts the sequence, even when armed
        if (key_wr)
        begin
            if (i_wdata == `DEA_KEY_FIRST)
            begin
                st_next.key = dea_pkg::DEA_KEY_HALF;
            end
            else if (i_wdata == `DEA_KEY_SECOND &&
                     st_reg.key == dea_pkg::DEA_KEY_HALF)
            begin
                st_next.key = dea_pkg::DEA_KEY_ARMED;
            end
        end

        // Done flag is software-cleared; a set in the same cycle wins
        if (flag2_wr)
        begin
            st_next.done_flag = i_wdata[`DEA_FLAG2_DONE];
        end

        // Writes to the data path are frozen while a cycle runs
        // The key port and done flag stay writable while busy
        if (i_wr && !busy)
        begin
            unique case (i_addr)
                `DEA_OFS_CTL:
                begin
                    st_next.ctl.flash_sel = i_wdata[`DEA_CTL_FLASH];
                    st_next.ctl.cfg_sel = i_wdata[`DEA_CTL_CFG];
                    st_next.ctl.row_wipe = i_wdata[`DEA_CTL_ROW];
                    st_next.ctl.aborted = i_wdata[`DEA_CTL_ABORT];
                    st_next.ctl.permit = i_wdata[`DEA_CTL_PERMIT];
                    // Fetch completes at once, so it never reads back set
                    if (i_wdata[`DEA_CTL_FETCH] &&
                        !i_wdata[`DEA_CTL_FLASH] &&
                        !i_wdata[`DEA_CTL_CFG])
                    begin
                        st_next.buffer = fetched;
                    end
                    launch_ok = i_wdata[`DEA_CTL_LAUNCH] &&
                                permit_before &&
                                key_armed &&
                                pwrt_done;
                    if (launch_ok)
                    begin
                        st_next.ctl.launch = 1'b1;
                        st_next.fsm = dea_pkg::DEA_ERASE;
                        st_next.cnt = ERASE_LAST;
                        // Flash and config launches run the timer only
                        st_next.to_array = !i_wdata[`DEA_CTL_FLASH] &&
                                           !i_wdata[`DEA_CTL_CFG];
                        st_next.flash_start = i_wdata[`DEA_CTL_FLASH] |
                                              i_wdata[`DEA_CTL_CFG];
                    end
                end
                `DEA_OFS_BUF:
                begin
                    st_next.buffer = i_wdata;
                end
                `DEA_OFS_IDX:
                begin
                    st_next.index = i_wdata;
                end
                default:
                begin
                    st_next.index = st_next.index;
                end
            endcase
        end

        // Self-timed erase then store; the array is touched only at the
        // last cycle of each phase, so a warm reset in the erase phase leaves
        // the old byte, and one in the store phase leaves it erased
        unique case (st_reg.fsm)
            dea_pkg::DEA_IDLE:
            begin
                st_next.cnt = st_next.cnt;
            end
            dea_pkg::DEA_ERASE:
            begin
                if (st_reg.cnt == '0)
                begin
                    // Last erase cycle: blank the byte, then store
                    erase_do = st_reg.to_array;
                    st_next.fsm = dea_pkg::DEA_STORE;
                    st_next.cnt = STORE_LAST;
                end
                else
                begin
                    st_next.cnt = st_reg.cnt - 1'b1;
                end
            end
            dea_pkg::DEA_STORE:
            begin
                if (st_reg.cnt == '0)
                begin
                    // Last store cycle: write the byte and report it
                    store_do = st_reg.to_array;
                    st_next.fsm = dea_pkg::DEA_IDLE;
                    st_next.ctl.launch = 1'b0;
                    st_next.ctl.row_wipe = 1'b0;
                    st_next.done_flag = 1'b1;
                end
                else
                begin
                    st_next.cnt = st_reg.cnt - 1'b1;
                end
            end
        endcase

        // Warm reset: permit and selects are left alone
        if (warm)
        begin
            if (busy)
            begin
                st_next.ctl.aborted = 1'b1;
                // A cut cycle must not look finished: the row wipe bit is
                // kept for tracing, and the done flag is not raised
                st_next.ctl.row_wipe = st_reg.ctl.row_wipe;
                st_next.done_flag = flag2_wr ? i_wdata[`DEA_FLAG2_DONE] : st_reg.done_flag;
            end
            erase_do = 1'b0;
            store_do = 1'b0;
            st_next.fsm = dea_pkg::DEA_IDLE;
            st_next.ctl.launch = 1'b0;
            st_next.cnt = '0;
            st_next.key = dea_pkg::DEA_KEY_NONE;
            st_next.buffer = 8'h00;
            st_next.index = 8'h00;
            st_next.flash_start = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            st_reg.fsm <= dea_pkg::DEA_IDLE;
            st_reg.key <= dea_pkg::DEA_KEY_NONE;
            // Power-on clears every control bit; permit must start low
            st_reg.ctl.flash_sel <= 1'b0;
            st_reg.ctl.cfg_sel <= 1'b0;
            st_reg.ctl.row_wipe <= 1'b0;
            st_reg.ctl.aborted <= 1'b0;
            st_reg.ctl.permit <= 1'b0;
            st_reg.ctl.launch <= 1'b0;
            st_reg.buffer <= 8'h00;
            st_reg.index <= 8'h00;
            st_reg.done_flag <= 1'b0;
            st_reg.to_array <= 1'b0;
            st_reg.cnt <= '0;
            // Power-up timer reloads on every power-on reset
            st_reg.pwrt_cnt <= PWRT_LOAD;
            st_reg.rdata <= 8'h00;
            st_reg.flash_start <= 1'b0;
            st_reg.ext_sync <= 2'b00;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------------
    // Array write port
    // ------------------------------------------------------------------
    // Kept apart from the state register because the array has no reset
    always_ff @(posedge i_clk)
    begin
        if (erase_do)
        begin
            mem_reg[st_reg.index] <= `DEA_ERASED;
        end
        else if (store_do)
        begin
            mem_reg[st_reg.index] <= st_reg.buffer;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Every output comes straight from a flop, so none can glitch
    assign o_rdata = st_reg.rdata;
    assign o_busy = st_reg.ctl.launch;
    assign o_done_flag = st_reg.done_flag;
    assign o_aborted = st_reg.ctl.aborted;
    // One-cycle pulse for the flash side, raised with the launch bit
    assign o_flash_start = st_reg.flash_start;
    assign o_flash_row_erase = st_reg.ctl.row_wipe;

endmodule

// ### verilog/dea_pkg.sv
// Types shared by the data EEPROM access controller.
// Assumes dea_regs.svh is on the include path.
`include "dea_regs.svh"

package dea_pkg;

    typedef enum logic [2:0]
    {
        DEA_IDLE = 3'b001,
        DEA_ERASE = 3'b010,
        DEA_STORE = 3'b100
    } dea_fsm_t;

    typedef enum logic [2:0]
    {
        DEA_KEY_NONE = 3'b001,
        DEA_KEY_HALF = 3'b010,
        DEA_KEY_ARMED = 3'b100
    } dea_key_t;

    typedef struct packed
    {
        logic flash_sel;
        logic cfg_sel;
        logic row_wipe;
        logic aborted;
        logic permit;
        logic launch;
    } dea_ctl_t;

    typedef struct packed
    {
        dea_fsm_t fsm;
        dea_key_t key;
        dea_ctl_t ctl;
        logic [7:0] buffer;
        logic [7:0] index;
        logic done_flag;
        logic to_array;
        logic [`DEA_CNT_W-1:0] cnt;
        logic [`DEA_CNT_W-1:0] pwrt_cnt;
        logic [7:0] rdata;
        logic flash_start;
        logic [1:0] ext_sync;
    } dea_state_t;

endpackage

// ### verilog/dea_regs.svh
// Register offsets, field positions, key and erased values, array depth and timing counts for
// the data EEPROM access controller.
// Assumes a byte-wide register port with 12-bit register addresses.
`ifndef DEA_REGS_SVH
`define DEA_REGS_SVH

// ----------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------
`define DEA_ADDR_W 12
`define DEA_OFS_FLAG2 12'hfa1
`define DEA_OFS_CTL 12'hfa6
`define DEA_OFS_KEY 12'hfa7
`define DEA_OFS_BUF 12'hfa8
`define DEA_OFS_IDX 12'hfa9

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define DEA_CTL_FLASH 7
`define DEA_CTL_CFG 6
`define DEA_CTL_ROW 4
`define DEA_CTL_ABORT 3
`define DEA_CTL_PERMIT 2
`define DEA_CTL_LAUNCH 1
`define DEA_CTL_FETCH 0
`define DEA_FLAG2_DONE 4

// ----------------------------------------------------------------------
// Values
// ----------------------------------------------------------------------
`define DEA_KEY_FIRST 8'h55
`define DEA_KEY_SECOND 8'haa
`define DEA_ERASED 8'hff
`define DEA_DEPTH 256

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define DEA_CLK_KHZ 10000
`define DEA_PWRT_MS 72
`define DEA_PWRT_CYCLES (`DEA_PWRT_MS * `DEA_CLK_KHZ)
`define DEA_PROG_CYCLES 40000
`define DEA_CNT_W 24

`endif
